// ===== rtl/fms_pkg.sv
// Shared constants and types for the flash mode and protection sequencer
package fms_pkg;
   localparam int FMS_BLOCK_BYTES = 131072;
   localparam int FMS_ADDR_W = 18;
   localparam int FMS_CORE_DW = 32;
   localparam int FMS_PROG_DW = 16;
   localparam int FMS_BLOCK_BIT = 17;
   localparam int FMS_MULTI_LSB = 8;
   localparam logic [17:0] FMS_UNLOCK1_ADDR = 18'h05554;
   localparam logic [7:0] FMS_UNLOCK1_DATA = 8'hAA;
   localparam logic [17:0] FMS_UNLOCK2_ADDR = 18'h0AAAA;
   localparam logic [7:0] FMS_UNLOCK2_DATA = 8'h55;
   localparam logic [7:0] FMS_CMD_PROGRAM = 8'hA0;
   localparam logic [7:0] FMS_CMD_CHIP_ERASE = 8'h10;
   localparam logic [7:0] FMS_CMD_BLOCK_ERASE = 8'h30;
   localparam logic [7:0] FMS_CMD_MULTI_ERASE = 8'h38;
   localparam logic [7:0] FMS_CMD_PROTECT = 8'h9A;
   localparam logic [7:0] FMS_CMD_UNPROTECT = 8'h6A;
   localparam logic [7:0] FMS_CMD_SUSPEND = 8'hB0;
   localparam logic [7:0] FMS_POLL_IDLE = 8'h80;
   localparam logic [31:0] FMS_DATA_RESET = 32'h0000_0000;
   localparam logic [17:0] FMS_ADDR_RESET = 18'h00000;
   localparam logic [1:0] FMS_PROT_RESET = 2'h0;

   typedef enum logic [1:0] {
      FMS_MODE_NONE = 2'b00,
      FMS_MODE_SINGLE_CHIP = 2'b01,
      FMS_MODE_SINGLE_BOOT = 2'b10,
      FMS_MODE_PROGRAMMER = 2'b11
   } fms_mode_t;

   typedef enum logic [2:0] {
      FMS_OP_NONE = 3'b000,
      FMS_OP_PROGRAM = 3'b001,
      FMS_OP_ERASE = 3'b010,
      FMS_OP_PROTECT = 3'b011,
      FMS_OP_UNPROTECT = 3'b100
   } fms_op_t;

   typedef enum logic [2:0] {
      FMS_S_IDLE = 3'b000,
      FMS_S_UNLK1 = 3'b001,
      FMS_S_UNLK2 = 3'b010,
      FMS_S_PDATA = 3'b011,
      FMS_S_START = 3'b100,
      FMS_S_WAIT = 3'b101
   } fms_state_t;
endpackage : fms_pkg

// ===== rtl/fms_mode_latch.sv
// Strap decode and mode hold for the flash sequencer
`timescale 1ns/1ps
module fms_mode_latch
   import fms_pkg::*;
(
   input wire logic clk_in,
   input wire logic reset_n_in,
   input wire logic reset_pin_in,
   input wire logic loader_select_in,
   input wire logic [3:0] mode_strap_in,
   input wire logic factory_strap_a_in,
   input wire logic factory_strap_b_in,
   output fms_mode_t mode_out,
   output logic core_run_out,
   output logic boot_rom_sel_out,
   output logic pins_released_out
);
   logic pin_q;
   logic released;
   fms_mode_t mode;
   fms_mode_t next_mode;
   wire logic release_edge = !pin_q && reset_pin_in;
   wire logic factory_low = !factory_strap_a_in && !factory_strap_b_in;
   wire logic prog_pattern = (mode_strap_in == 4'b0011) && factory_strap_a_in
      && !factory_strap_b_in;

   // Decode only while the pin is low or on its release edge
   always_comb begin
      next_mode = mode;
      if (!reset_pin_in) begin
         next_mode = prog_pattern ? FMS_MODE_PROGRAMMER : FMS_MODE_NONE;
      end else if (release_edge) begin
         if (factory_low) begin
            next_mode = loader_select_in ? FMS_MODE_SINGLE_CHIP : FMS_MODE_SINGLE_BOOT;
         end else begin
            next_mode = FMS_MODE_NONE;
         end
      end
   end

   logic core_run;
   logic boot_sel;
   wire logic next_core_run = (next_mode == FMS_MODE_SINGLE_CHIP)
      || (next_mode == FMS_MODE_SINGLE_BOOT);
   wire logic next_boot_sel = (next_mode == FMS_MODE_SINGLE_BOOT);

   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         pin_q <= 1'b0;
         mode <= FMS_MODE_NONE;
         released <= 1'b0;
         core_run <= 1'b0;
         boot_sel <= 1'b0;
      end else begin
         pin_q <= reset_pin_in;
         mode <= next_mode; // [RL8] [RL9] [RL17]
         released <= reset_pin_in && pin_q; // [RL12]
         core_run <= next_core_run; // [RL13]
         boot_sel <= next_boot_sel; // [RL14]
      end
   end

   assign mode_out = mode;
   assign core_run_out = core_run;
   assign boot_rom_sel_out = boot_sel;
   assign pins_released_out = released;

   property p_mode_hold;
      @(posedge clk_in) disable iff (!reset_n_in)
      (pin_q && reset_pin_in) |=> $stable(mode);
   endproperty
   a_mode_hold: assert property (p_mode_hold) else $error("mode changed after release"); // [RL17]

   property p_single_chip;
      @(posedge clk_in) disable iff (!reset_n_in)
      (release_edge && loader_select_in && factory_low) |=> (mode == FMS_MODE_SINGLE_CHIP);
   endproperty
   a_single_chip: assert property (p_single_chip) else $error("single-chip not decoded"); // [RL8]

   property p_single_boot;
      @(posedge clk_in) disable iff (!reset_n_in)
      (release_edge && !loader_select_in && factory_low)
         |=> (mode == FMS_MODE_SINGLE_BOOT) && boot_rom_sel_out;
   endproperty
   a_single_boot: assert property (p_single_boot) else $error("single-boot not decoded"); // [RL14]
endmodule : fms_mode_latch

// ===== rtl/fms_port_mux.sv
// Selects core or programmer access path and zero-extends programmer data
`timescale 1ns/1ps
module fms_port_mux
   import fms_pkg::*;
#(
   parameter int CORE_DW = FMS_CORE_DW,
   parameter int PROG_DW = FMS_PROG_DW
) (
   input fms_mode_t mode_in,
   input wire logic core_wr_in,
   input wire logic [FMS_ADDR_W-1:0] core_addr_in,
   input wire logic [CORE_DW-1:0] core_wdata_in,
   input wire logic prog_wr_in,
   input wire logic [FMS_ADDR_W-1:0] prog_addr_in,
   input wire logic [PROG_DW-1:0] prog_wdata_in,
   output logic wr_out,
   output logic [FMS_ADDR_W-1:0] addr_out,
   output logic [CORE_DW-1:0] wdata_out
);
   wire logic prog_sel = (mode_in == FMS_MODE_PROGRAMMER);
   wire logic core_sel = (mode_in == FMS_MODE_SINGLE_CHIP)
      || (mode_in == FMS_MODE_SINGLE_BOOT);
   wire logic [CORE_DW-1:0] prog_wide = {{(CORE_DW-PROG_DW){1'b0}}, prog_wdata_in};

   // Programmer writes only the low half of the word
   assign wr_out = (prog_sel && prog_wr_in) || (core_sel && core_wr_in);
   assign addr_out = prog_sel ? prog_addr_in : core_addr_in;
   assign wdata_out = prog_sel ? prog_wide : core_wdata_in; // [RL2]
endmodule : fms_port_mux

// ===== rtl/fms_sequencer.sv
// Flash command sequencer with mode decode, block protection and read lock
// Contract
// RL1: Two 128-Kbyte blocks, each separately protectable
// RL2: Core 32-bit path, programmer 16-bit path
// RL3: Sequencer detects commands, runs operations alone
// RL4: Program and erases, polled status, no suspend
// RL5: Protection only by command, never by voltage
// RL6: Both blocks protected locks programmer reads
// RL7: Unprotect erases first, then clears protection
// RL8: Straps at reset release select chip or boot
// RL9: Programmer mode needs reset low, fixed straps
// RL10: Outside keeps mode inputs steady while used
// RL11: Outside drives don't-care straps to levels
// RL12: Strap pins free for I/O after release
// RL13: Single-chip mode runs core from flash
// RL14: Single-boot mode runs core from boot ROM
// RL15: Chip and multi-block erase skip protected blocks
// RL16: Outside holds reset low 10 ms minimum
// RL17: Mode latched at release, held until reset
`timescale 1ns/1ps
module fms_sequencer
   import fms_pkg::*;
#(
   parameter int CORE_DW = FMS_CORE_DW,
   parameter int PROG_DW = FMS_PROG_DW
) (
   input wire logic clk_in,
   input wire logic reset_n_in,
   input wire logic reset_pin_in,
   input wire logic loader_select_in,
   input wire logic [3:0] mode_strap_in,
   input wire logic factory_strap_a_in,
   input wire logic factory_strap_b_in,
   input wire logic core_wr_in,
   input wire logic [FMS_ADDR_W-1:0] core_addr_in,
   input wire logic [CORE_DW-1:0] core_wdata_in,
   input wire logic prog_wr_in,
   input wire logic [FMS_ADDR_W-1:0] prog_addr_in,
   input wire logic [PROG_DW-1:0] prog_wdata_in,
   input wire logic [CORE_DW-1:0] arr_rdata_in,
   input wire logic arr_done_in,
   input wire logic [1:0] arr_prot_in,
   output fms_mode_t mode_out,
   output logic core_run_out,
   output logic boot_rom_sel_out,
   output logic pins_released_out,
   output logic [CORE_DW-1:0] core_rdata_out,
   output logic [PROG_DW-1:0] prog_rdata_out,
   output logic prog_read_lock_out,
   output logic status_busy_out,
   output logic [7:0] poll_data_out,
   output fms_op_t arr_op_out,
   output logic arr_start_out,
   output logic [1:0] arr_block_mask_out,
   output logic [FMS_ADDR_W-1:0] arr_addr_out,
   output logic [CORE_DW-1:0] arr_wdata_out
);
   fms_mode_t mode;
   logic wr;
   logic [FMS_ADDR_W-1:0] addr;
   logic [CORE_DW-1:0] wdata;

   fms_state_t state;
   fms_state_t next_state;
   fms_op_t op;
   fms_op_t next_op;
   logic [1:0] mask;
   logic [1:0] next_mask;
   logic [1:0] prot;
   logic unprot_pending;
   logic next_unprot_pending;
   logic [FMS_ADDR_W-1:0] op_addr;
   logic [CORE_DW-1:0] op_data;
   logic lock;
   logic busy;
   logic [7:0] poll;

   fms_mode_latch u_mode (
      .clk_in(clk_in),
      .reset_n_in(reset_n_in),
      .reset_pin_in(reset_pin_in),
      .loader_select_in(loader_select_in),
      .mode_strap_in(mode_strap_in),
      .factory_strap_a_in(factory_strap_a_in),
      .factory_strap_b_in(factory_strap_b_in),
      .mode_out(mode),
      .core_run_out(core_run_out), // [RL13]
      .boot_rom_sel_out(boot_rom_sel_out),
      .pins_released_out(pins_released_out)
   );

   fms_port_mux #(
      .CORE_DW(CORE_DW),
      .PROG_DW(PROG_DW)
   ) u_mux (
      .mode_in(mode),
      .core_wr_in(core_wr_in),
      .core_addr_in(core_addr_in),
      .core_wdata_in(core_wdata_in),
      .prog_wr_in(prog_wr_in),
      .prog_addr_in(prog_addr_in),
      .prog_wdata_in(prog_wdata_in),
      .wr_out(wr),
      .addr_out(addr),
      .wdata_out(wdata)
   );

   assign mode_out = mode;

   // Command decode
   wire logic [7:0] wbyte = wdata[7:0];
   wire logic unlock1_hit = wr && (addr == FMS_UNLOCK1_ADDR) && (wbyte == FMS_UNLOCK1_DATA);
   wire logic unlock2_hit = wr && (addr == FMS_UNLOCK2_ADDR) && (wbyte == FMS_UNLOCK2_DATA);
   wire logic addr_block = addr[FMS_BLOCK_BIT];
   wire logic [1:0] addr_onehot = addr_block ? 2'b10 : 2'b01;
   wire logic [1:0] free_blocks = ~prot;
   wire logic cmd_chip = wr && (wbyte == FMS_CMD_CHIP_ERASE);
   wire logic cmd_block = wr && (wbyte == FMS_CMD_BLOCK_ERASE);
   wire logic cmd_multi = wr && (wbyte == FMS_CMD_MULTI_ERASE);
   wire logic cmd_prot = wr && (wbyte == FMS_CMD_PROTECT);
   wire logic cmd_unprot = wr && (wbyte == FMS_CMD_UNPROTECT);
   wire logic cmd_prog = wr && (wbyte == FMS_CMD_PROGRAM);
   // Protected blocks are dropped from chip, block and multi-block erase masks, but not from the unprotect erase
   wire logic [1:0] chip_mask = free_blocks; // [RL15]
   wire logic [1:0] block_mask = addr_onehot & free_blocks; // [RL1]
   // Mask sits above the command byte, whose low bits are fixed
   wire logic [1:0] multi_mask = wdata[FMS_MULTI_LSB+:2] & free_blocks; // [RL15]
   wire logic prog_blocked = prot[addr_block];
   wire logic launch = (next_state == FMS_S_START);

   // Anything not recognised drops back to idle; suspend is such a code
   always_comb begin
      next_state = state;
      next_op = op;
      next_mask = mask;
      next_unprot_pending = unprot_pending;
      unique case (state)
         FMS_S_IDLE: begin
            if (unlock1_hit) begin
               next_state = FMS_S_UNLK1;
            end
         end
         FMS_S_UNLK1: begin
            if (wr) begin
               next_state = unlock2_hit ? FMS_S_UNLK2 : FMS_S_IDLE;
            end
         end
         FMS_S_UNLK2: begin
            if (wr) begin
               next_state = FMS_S_IDLE; // [RL4]
               if (cmd_prog) begin
                  next_state = FMS_S_PDATA;
               end else if (cmd_chip && (chip_mask != 2'b00)) begin
                  next_state = FMS_S_START; // [RL3]
                  next_op = FMS_OP_ERASE;
                  next_mask = chip_mask;
               end else if (cmd_block && (block_mask != 2'b00)) begin
                  next_state = FMS_S_START;
                  next_op = FMS_OP_ERASE;
                  next_mask = block_mask;
               end else if (cmd_multi && (multi_mask != 2'b00)) begin
                  next_state = FMS_S_START;
                  next_op = FMS_OP_ERASE;
                  next_mask = multi_mask;
               end else if (cmd_prot) begin
                  next_state = FMS_S_START; // [RL5]
                  next_op = FMS_OP_PROTECT;
                  next_mask = addr_onehot;
               end else if (cmd_unprot) begin
                  next_state = FMS_S_START; // [RL7]
                  next_op = FMS_OP_ERASE;
                  next_mask = 2'b11;
                  next_unprot_pending = 1'b1;
               end
            end
         end
         FMS_S_PDATA: begin
            if (wr) begin
               next_state = prog_blocked ? FMS_S_IDLE : FMS_S_START; // [RL1]
               next_op = FMS_OP_PROGRAM;
               next_mask = addr_onehot;
            end
         end
         FMS_S_START: begin
            next_state = FMS_S_WAIT;
         end
         FMS_S_WAIT: begin
            if (arr_done_in) begin
               if (unprot_pending) begin
                  // Protection cleared only after the erase completes
                  next_state = FMS_S_START; // [RL7]
                  next_op = FMS_OP_UNPROTECT;
                  next_unprot_pending = 1'b0;
               end else begin
                  next_state = FMS_S_IDLE;
                  next_op = FMS_OP_NONE;
               end
            end
         end
         default: begin
            next_state = FMS_S_IDLE;
            next_op = FMS_OP_NONE;
            next_unprot_pending = 1'b0;
         end
      endcase
   end

   // Capture target address and data only when an operation is launched
   wire logic capture = launch && (state != FMS_S_WAIT);
   wire logic [7:0] next_poll = busy ? {~op_data[7], ~poll[6], 6'h00} : FMS_POLL_IDLE;
   wire logic [PROG_DW-1:0] prog_half = addr[1] ? arr_rdata_in[CORE_DW-1:PROG_DW]
      : arr_rdata_in[PROG_DW-1:0];

   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         state <= FMS_S_IDLE;
         op <= FMS_OP_NONE;
         mask <= FMS_PROT_RESET;
         unprot_pending <= 1'b0;
         op_addr <= FMS_ADDR_RESET;
         op_data <= FMS_DATA_RESET;
         arr_start_out <= 1'b0;
         busy <= 1'b0;
      end else begin
         state <= next_state;
         op <= next_op;
         mask <= next_mask;
         unprot_pending <= next_unprot_pending;
         arr_start_out <= launch;
         busy <= launch || (next_state == FMS_S_WAIT); // [RL4]
         if (capture) begin
            op_addr <= addr;
            op_data <= wdata;
         end
      end
   end

   // Protection bits live in the array cells; keep a local copy
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         prot <= FMS_PROT_RESET;
         lock <= 1'b0;
         poll <= FMS_POLL_IDLE;
         core_rdata_out <= FMS_DATA_RESET;
         prog_rdata_out <= FMS_DATA_RESET[PROG_DW-1:0];
      end else begin
         prot <= arr_prot_in;
         lock <= &prot; // [RL6]
         poll <= next_poll;
         core_rdata_out <= busy ? {{(CORE_DW-8){1'b0}}, poll} : arr_rdata_in;
         if (lock && (mode == FMS_MODE_PROGRAMMER)) begin
            prog_rdata_out <= '0; // [RL6]
         end else begin
            prog_rdata_out <= busy ? {{(PROG_DW-8){1'b0}}, poll} : prog_half; // [RL2]
         end
      end
   end

   assign prog_read_lock_out = lock;
   assign status_busy_out = busy;
   assign poll_data_out = poll;
   assign arr_op_out = op;
   assign arr_block_mask_out = mask;
   assign arr_addr_out = op_addr;
   assign arr_wdata_out = op_data;

   property p_lock;
      @(posedge clk_in) disable iff (!reset_n_in)
      (&arr_prot_in) ##1 (&arr_prot_in) |=> prog_read_lock_out;
   endproperty
   a_lock: assert property (p_lock) else $error("read lock missing with both protected"); // [RL6]

   property p_skip_protected;
      @(posedge clk_in) disable iff (!reset_n_in)
      (arr_start_out && (arr_op_out == FMS_OP_ERASE) && !unprot_pending)
         |-> ((arr_block_mask_out & prot) == 2'b00);
   endproperty
   a_skip_protected: assert property (p_skip_protected) else $error("erase hits protected"); // [RL15]

   property p_unprot_order;
      @(posedge clk_in) disable iff (!reset_n_in)
      (arr_start_out && (arr_op_out == FMS_OP_UNPROTECT))
         |-> $past(arr_done_in) && ($past(arr_op_out) == FMS_OP_ERASE);
   endproperty
   a_unprot_order: assert property (p_unprot_order) else $error("unprotect before erase"); // [RL7]

   property p_chip_launch;
      @(posedge clk_in) disable iff (!reset_n_in)
      (state == FMS_S_UNLK2 && cmd_chip && chip_mask != 2'b00)
         |=> arr_start_out && (arr_op_out == FMS_OP_ERASE) ##1 !arr_start_out;
   endproperty
   a_chip_launch: assert property (p_chip_launch) else $error("chip erase not launched"); // [RL3]

   property p_busy;
      @(posedge clk_in) disable iff (!reset_n_in)
      arr_start_out |-> status_busy_out ##1 status_busy_out;
   endproperty
   a_busy: assert property (p_busy) else $error("busy not shown during operation"); // [RL4]

   property p_protect_by_cmd;
      @(posedge clk_in) disable iff (!reset_n_in)
      (arr_start_out && (arr_op_out == FMS_OP_PROTECT))
         |-> $past(state == FMS_S_UNLK2 && cmd_prot);
   endproperty
   a_protect_by_cmd: assert property (p_protect_by_cmd) else $error("protect without command"); // [RL5]

   property p_prog_guard;
      @(posedge clk_in) disable iff (!reset_n_in)
      (arr_start_out && (arr_op_out == FMS_OP_PROGRAM))
         |-> !prot[arr_addr_out[FMS_BLOCK_BIT]];
   endproperty
   a_prog_guard: assert property (p_prog_guard) else $error("program into protected block"); // [RL1]

   property p_narrow;
      @(posedge clk_in) disable iff (!reset_n_in)
      (mode == FMS_MODE_PROGRAMMER) |-> (wdata[CORE_DW-1:PROG_DW] == '0);
   endproperty
   a_narrow: assert property (p_narrow) else $error("programmer path wider than 16 bits"); // [RL2]

   property p_suspend_ignored;
      @(posedge clk_in) disable iff (!reset_n_in)
      (state == FMS_S_UNLK2 && wr && wbyte == FMS_CMD_SUSPEND) |=> (state == FMS_S_IDLE);
   endproperty
   a_suspend_ignored: assert property (p_suspend_ignored) else $error("suspend accepted"); // [RL4]

   property p_run_flash;
      @(posedge clk_in) disable iff (!reset_n_in)
      (mode == FMS_MODE_SINGLE_CHIP) |-> core_run_out && !boot_rom_sel_out;
   endproperty
   a_run_flash: assert property (p_run_flash) else $error("single-chip not run from flash"); // [RL13]
endmodule : fms_sequencer

// ===== bench/fms_array_model.sv
// Behavioural flash array on the far side of the sequencer
`timescale 1ns/1ps
module fms_array_model
   import fms_pkg::*;
(
   input wire logic clk_in,
   input wire logic arr_start_in,
   input fms_op_t arr_op_in,
   input wire logic [FMS_ADDR_W-1:0] arr_addr_in,
   input wire logic [FMS_ADDR_W-1:0] rd_addr_in,
   input wire logic [7:0] delay_in,
   output logic arr_done_out,
   output logic [1:0] arr_prot_out,
   output logic [31:0] arr_rdata_out
);
   fms_op_t op;
   logic blk;
   logic busy;
   logic [7:0] count;
   // Protect bits sit in flash cells, so the block reset never clears them
   initial begin
      arr_prot_out = 2'h0;
      arr_done_out = 1'b0;
      busy = 1'b0;
      count = 8'h00;
      blk = 1'b0;
      op = FMS_OP_NONE;
   end
   assign arr_rdata_out = {16'hC3A5 ^ rd_addr_in[15:0], rd_addr_in[15:0]};
   // Delay per operation lets the bench answer promptly or slowly
   always @(posedge clk_in) begin
      arr_done_out <= 1'b0;
      if (arr_start_in) begin
         busy <= 1'b1;
         op <= arr_op_in;
         blk <= arr_addr_in[FMS_BLOCK_BIT];
         count <= delay_in;
      end else if (busy) begin
         if (count == 8'h00) begin
            busy <= 1'b0;
            arr_done_out <= 1'b1;
            if (op == FMS_OP_PROTECT) arr_prot_out[blk] <= 1'b1;
            if (op == FMS_OP_UNPROTECT) arr_prot_out <= 2'h0;
         end else begin
            count <= count - 8'h01;
         end
      end
   end
endmodule : fms_array_model

// ===== bench/tb_top.sv
// Self-checking bench for the flash mode and protection sequencer
`timescale 1ns/1ps
module tb_top;
   import fms_pkg::*;
   logic clk_in = 1'b0;
   logic reset_n_in = 1'b0;
   logic reset_pin_in = 1'b0;
   logic loader_select_in = 1'b1;
   logic [3:0] mode_strap_in = 4'h0;
   logic factory_strap_a_in = 1'b0;
   logic factory_strap_b_in = 1'b0;
   logic core_wr_in = 1'b0;
   logic [17:0] core_addr_in = 18'h00000;
   logic [31:0] core_wdata_in = 32'h0000_0000;
   logic prog_wr_in = 1'b0;
   logic [17:0] prog_addr_in = 18'h00000;
   logic [15:0] prog_wdata_in = 16'h0000;
   logic [7:0] delay = 8'h00;
   logic [17:0] rd_addr;
   logic [31:0] arr_rdata;
   logic arr_done;
   logic [1:0] arr_prot;
   fms_mode_t mode_out;
   fms_op_t arr_op_out;
   logic core_run_out, boot_rom_sel_out, pins_released_out, prog_read_lock_out;
   logic status_busy_out, arr_start_out;
   logic [31:0] core_rdata_out, arr_wdata_out;
   logic [15:0] prog_rdata_out;
   logic [7:0] poll_data_out;
   logic [1:0] arr_block_mask_out;
   logic [17:0] arr_addr_out;
   int failures = 0;
   int checks_done = 0;
   int cycles = 0;

   always #20 clk_in = ~clk_in;
   assign rd_addr = (mode_out == FMS_MODE_PROGRAMMER) ? prog_addr_in : core_addr_in;

   fms_sequencer u_fms_sequencer (
      .clk_in(clk_in), .reset_n_in(reset_n_in), .reset_pin_in(reset_pin_in),
      .loader_select_in(loader_select_in), .mode_strap_in(mode_strap_in),
      .factory_strap_a_in(factory_strap_a_in), .factory_strap_b_in(factory_strap_b_in),
      .core_wr_in(core_wr_in), .core_addr_in(core_addr_in), .core_wdata_in(core_wdata_in),
      .prog_wr_in(prog_wr_in), .prog_addr_in(prog_addr_in), .prog_wdata_in(prog_wdata_in),
      .arr_rdata_in(arr_rdata), .arr_done_in(arr_done), .arr_prot_in(arr_prot),
      .mode_out(mode_out), .core_run_out(core_run_out), .boot_rom_sel_out(boot_rom_sel_out),
      .pins_released_out(pins_released_out), .core_rdata_out(core_rdata_out),
      .prog_rdata_out(prog_rdata_out), .prog_read_lock_out(prog_read_lock_out),
      .status_busy_out(status_busy_out), .poll_data_out(poll_data_out),
      .arr_op_out(arr_op_out), .arr_start_out(arr_start_out),
      .arr_block_mask_out(arr_block_mask_out), .arr_addr_out(arr_addr_out),
      .arr_wdata_out(arr_wdata_out)
   );

   fms_array_model u_fms_array_model (
      .clk_in(clk_in), .arr_start_in(arr_start_out), .arr_op_in(arr_op_out),
      .arr_addr_in(arr_addr_out), .rd_addr_in(rd_addr), .delay_in(delay),
      .arr_done_out(arr_done), .arr_prot_out(arr_prot), .arr_rdata_out(arr_rdata)
   );

   task automatic complete_run();
      if (failures == 0 && checks_done > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : complete_run

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // One-cycle write strobe on the selected source
   task automatic wr(input logic sel, input logic [17:0] a, input logic [31:0] d);
      @(posedge clk_in);
      if (sel) begin
         prog_wr_in <= 1'b1;
         prog_addr_in <= a;
         prog_wdata_in <= d[15:0];
      end else begin
         core_wr_in <= 1'b1;
         core_addr_in <= a;
         core_wdata_in <= d;
      end
      @(posedge clk_in);
      prog_wr_in <= 1'b0;
      core_wr_in <= 1'b0;
   endtask : wr

   task automatic cmd(input logic sel, input logic [7:0] code, input logic [17:0] a,
      input logic [1:0] m = 2'b00);
      wr(sel, FMS_UNLOCK1_ADDR, {24'h0, FMS_UNLOCK1_DATA});
      wr(sel, FMS_UNLOCK2_ADDR, {24'h0, FMS_UNLOCK2_DATA});
      wr(sel, a, {22'h0, m, code});
   endtask : cmd

   // Bounded wait for a launch, then op and block mask
   task automatic wait_op(input fms_op_t op, input logic [1:0] mask);
      #1;
      for (int i = 0; i < 60; i++) begin
         if (arr_start_out === 1'b1 && arr_op_out === op) break;
         @(posedge clk_in);
         #1;
      end
      chk({31'h0, arr_start_out}, 32'h1);
      chk({29'h0, arr_op_out}, {29'h0, op});
      chk({30'h0, arr_block_mask_out}, {30'h0, mask});
      chk({31'h0, status_busy_out}, 32'h1);
   endtask : wait_op

   task automatic wait_idle();
      for (int i = 0; i < 60; i++) begin
         @(posedge clk_in);
         #1;
         if (status_busy_out === 1'b0) break;
      end
      repeat (3) @(posedge clk_in);
      #1;
      chk({24'h0, poll_data_out}, {24'h0, FMS_POLL_IDLE});
   endtask : wait_idle

   // A refused command must not launch anything
   task automatic quiet();
      logic seen;
      seen = 1'b0;
      repeat (8) begin
         @(posedge clk_in);
         #1;
         seen = seen | arr_start_out | status_busy_out;
      end
      chk({31'h0, seen}, 32'h0);
   endtask : quiet

   task automatic rd(input logic sel, input logic [17:0] a, input logic [31:0] exp);
      @(posedge clk_in);
      if (sel) prog_addr_in <= a;
      else core_addr_in <= a;
      repeat (2) @(posedge clk_in);
      #1;
      chk(sel ? {16'h0, prog_rdata_out} : core_rdata_out, exp);
   endtask : rd

   task automatic pin_cycle(input logic loader);
      @(posedge clk_in);
      reset_pin_in <= 1'b0;
      loader_select_in <= loader;
      repeat (3) @(posedge clk_in);
      reset_pin_in <= 1'b1;
      repeat (5) @(posedge clk_in);
      #1;
   endtask : pin_cycle

   always @(posedge clk_in) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         failures++;
         complete_run();
      end
   end

   initial begin
      repeat (16) @(posedge clk_in);
      reset_n_in <= 1'b1;
      pin_cycle(1'b1);
      chk({30'h0, mode_out}, {30'h0, FMS_MODE_SINGLE_CHIP});
      chk({30'h0, core_run_out, boot_rom_sel_out}, 32'h2);
      chk({31'h0, pins_released_out}, 32'h1);
      loader_select_in <= 1'b0;
      mode_strap_in <= 4'hF;
      repeat (4) @(posedge clk_in);
      #1;
      chk({30'h0, mode_out}, {30'h0, FMS_MODE_SINGLE_CHIP});
      loader_select_in <= 1'b1;
      mode_strap_in <= 4'h0;
      rd(1'b0, 18'h00104, 32'hC2A1_0104);
      // Slow array first, prompt array later
      delay <= 8'd20;
      cmd(1'b0, FMS_CMD_PROTECT, 18'h20000);
      wait_op(FMS_OP_PROTECT, 2'b10);
      wait_idle();
      cmd(1'b0, FMS_CMD_CHIP_ERASE, FMS_UNLOCK1_ADDR);
      wait_op(FMS_OP_ERASE, 2'b01);
      wait_idle();
      cmd(1'b0, FMS_CMD_BLOCK_ERASE, 18'h20000);
      quiet();
      cmd(1'b0, FMS_CMD_BLOCK_ERASE, 18'h00000);
      wait_op(FMS_OP_ERASE, 2'b01);
      wait_idle();
      cmd(1'b0, FMS_CMD_MULTI_ERASE, FMS_UNLOCK1_ADDR, 2'b11);
      wait_op(FMS_OP_ERASE, 2'b01);
      wait_idle();
      cmd(1'b0, FMS_CMD_PROGRAM, FMS_UNLOCK1_ADDR);
      wr(1'b0, 18'h20010, 32'h1234_5678);
      quiet();
      cmd(1'b0, FMS_CMD_PROGRAM, FMS_UNLOCK1_ADDR);
      wr(1'b0, 18'h00010, 32'h1234_5678);
      wait_op(FMS_OP_PROGRAM, 2'b01);
      chk({14'h0, arr_addr_out}, 32'h0000_0010);
      chk(arr_wdata_out, 32'h1234_5678);
      repeat (2) @(posedge clk_in);
      #1;
      chk({31'h0, poll_data_out[7]}, 32'h1);
      wait_idle();
      cmd(1'b0, FMS_CMD_SUSPEND, FMS_UNLOCK1_ADDR);
      quiet();
      delay <= 8'd0;
      cmd(1'b0, FMS_CMD_PROTECT, 18'h00000);
      wait_op(FMS_OP_PROTECT, 2'b01);
      wait_idle();
      chk({31'h0, prog_read_lock_out}, 32'h1);
      cmd(1'b0, FMS_CMD_UNPROTECT, FMS_UNLOCK1_ADDR);
      wait_op(FMS_OP_ERASE, 2'b11);
      wait_op(FMS_OP_UNPROTECT, 2'b11);
      wait_idle();
      chk({31'h0, prog_read_lock_out}, 32'h0);
      pin_cycle(1'b0);
      chk({30'h0, mode_out}, {30'h0, FMS_MODE_SINGLE_BOOT});
      chk({30'h0, core_run_out, boot_rom_sel_out}, 32'h3);
      // Programmer entry: pin low, straps then left steady
      @(posedge clk_in);
      reset_pin_in <= 1'b0;
      mode_strap_in <= 4'h3;
      factory_strap_a_in <= 1'b1;
      repeat (4) @(posedge clk_in);
      #1;
      chk({30'h0, mode_out}, {30'h0, FMS_MODE_PROGRAMMER});
      cmd(1'b0, FMS_CMD_CHIP_ERASE, FMS_UNLOCK1_ADDR);
      quiet();
      cmd(1'b1, FMS_CMD_PROGRAM, FMS_UNLOCK1_ADDR);
      wr(1'b1, 18'h00008, 32'h0000_BEEF);
      wait_op(FMS_OP_PROGRAM, 2'b01);
      chk(arr_wdata_out, 32'h0000_BEEF);
      wait_idle();
      rd(1'b1, 18'h00006, 32'h0000_C3A3);
      cmd(1'b1, FMS_CMD_PROTECT, 18'h00000);
      wait_op(FMS_OP_PROTECT, 2'b01);
      wait_idle();
      cmd(1'b1, FMS_CMD_PROTECT, 18'h20000);
      wait_op(FMS_OP_PROTECT, 2'b10);
      wait_idle();
      chk({31'h0, prog_read_lock_out}, 32'h1);
      rd(1'b1, 18'h00004, 32'h0000_0000);
      complete_run();
   end
endmodule : tb_top
